/* drww_kick_model.sv */
/*
 * Supervised processor model: drives falling-edge kicks on the watchdog kick pin.
 * Assumes a free-running clk_sys; the bench calls its task with the edge spacing it wants.
 */
`timescale 1ns/1ps
module drww_kick_model (
    // clock
    input wire logic clk_sys,
    // kick pin
    output logic watchdog_kick_in
);
    initial watchdog_kick_in = 1'h1;
    // ----------------------------------------------------------------
    // one kick, falling edge space cycles after the previous one
    // ----------------------------------------------------------------
    task automatic kick(input int space);
        repeat (space - 3) @(posedge clk_sys);
        watchdog_kick_in <= 1'h0;
        repeat (3) @(posedge clk_sys);
        watchdog_kick_in <= 1'h1;
    endtask
endmodule

/* drww_pkg.sv */
/*
 * Shared constants and types of the dual reset / window watchdog supervisor:
 * register offsets, field positions, reset values, pin indexes and state codes.
 * Assumes a 32-bit classic Wishbone register bus with byte addresses.
 */
package drww_pkg;
    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_POR1_DELAY = 8'h00;
    localparam logic [7:0] OFF_POR2_DELAY = 8'h04;
    localparam logic [7:0] OFF_WINDOW = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] POR_DELAY_RST = 32'h0000_1000;
    localparam logic [31:0] WINDOW_RST = 32'h0000_0100;
    localparam logic [31:0] IRQ_MASK_RST = 32'h0000_0000;
    // ----------------------------------------------------------------
    // window derivation: upper = setting << 4, lower = setting, pulse = upper / 8
    // ----------------------------------------------------------------
    localparam int UPPER_SHIFT = 4;
    localparam int PULSE_SHIFT = 3;
    // ----------------------------------------------------------------
    // interrupt status / mask bits
    // ----------------------------------------------------------------
    localparam int IRQ_EARLY = 0;
    localparam int IRQ_LATE = 1;
    localparam int IRQ_CHANNEL_ONE_RESET_N = 2;
    localparam int IRQ_CHANNEL_TWO_RESET_N = 3;
    localparam int IRQ_W = 4;
    // ----------------------------------------------------------------
    // synchronised pin indexes
    // ----------------------------------------------------------------
    localparam int PIN_OK1 = 0;
    localparam int PIN_OK2 = 1;
    localparam int PIN_KICK = 2;
    localparam int PIN_WDE = 3;
    localparam int PIN_SEL0 = 4;
    localparam int PIN_SEL1 = 5;
    localparam int PIN_W = 6;
    // ----------------------------------------------------------------
    // strap capture and sequencing select encodings
    // ----------------------------------------------------------------
    localparam logic [3:0] STRAP_CYCLES = 4'h8;
    localparam logic [1:0] SEL_PIN_LOW = 2'h1;
    localparam logic [1:0] SEL_PIN_HIGH = 2'h2;
    typedef enum logic [1:0] {
        MODE_OPEN = 2'h0,
        MODE_LOW = 2'h1,
        MODE_HIGH = 2'h2
    } drww_mode_type;
    typedef enum logic [2:0] {
        WD_IDLE = 3'h1,
        WD_RUN = 3'h2,
        WD_FAULT = 3'h4
    } drww_wd_state_type;
    // status register layout, bits 7:0
    typedef struct packed {
        drww_mode_type mode;
        drww_wd_state_type wd_state;
        logic fault_n;
        logic [1:0] rst_n;
    } drww_status_type;
endpackage

/* drww_supervisor.sv */
/*
 * Dual power-on reset channels and windowed watchdog, with a Wishbone
 * register slave and a masked, sticky interrupt.
 * Assumes comparator results and kick / disable / select straps arrive
 * asynchronously as logic levels; one clock clk_sys with synchronous reset.
 */
// Register access over Wishbone and the address map were decided locally.
// Overview of operation
// - reset low while output under threshold
// - above threshold, release reset after delay
// - each channel has own delay setting
// - disable pin turns watchdog off
// - too early or late kick raises fault
// - fault low for upper bound eighth
// - fault ends at timeout or reset low
// - both bounds from one window setting
// - select high: chained start, watchdog after both
// - select low: joint resets after channel one
// - select open: watchdog after first reset
`timescale 1ns/1ps
module drww_supervisor
    import drww_pkg::*;
#(
    parameter int DLY_W = 24,
    parameter int WIN_W = 16
) (
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // analog comparator results and pins
    input wire logic [1:0] output_feedback_sense,
    input wire logic watchdog_kick_in,
    input wire logic watchdog_disable_in,
    input wire logic [1:0] seq_select_in,
    // supervisory outputs
    output logic channel_one_reset_n,
    output logic channel_two_reset_n,
    output logic watchdog_fault_n,
    output logic channel_two_run,
    output logic irq
);
    localparam int CNT_W = WIN_W + UPPER_SHIFT;

    if (DLY_W < 2 || DLY_W > 32 || WIN_W < 4 || CNT_W > 32) begin : g_bad_width
        $error("drww_supervisor: unsupported width parameters");
    end

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] s1_q;
    logic [PIN_W-1:0] s2_q;
    logic [PIN_W-1:0] s3_q;
    logic [PIN_W-1:0] pin_q;
    assign pin_raw = {seq_select_in, watchdog_disable_in, watchdog_kick_in, output_feedback_sense};

    for (genvar g = 0; g < PIN_W; g++) begin : g_sync
        always_ff @(posedge clk_sys) begin
            if (!rst_b) begin
                s1_q[g] <= 1'b0;
                s2_q[g] <= 1'b0;
                s3_q[g] <= 1'b0;
                pin_q[g] <= 1'b0;
            end else if (ce) begin
                s1_q[g] <= pin_raw[g];
                s2_q[g] <= s1_q[g];
                s3_q[g] <= s2_q[g];
                if (s2_q[g] == s3_q[g]) begin
                    pin_q[g] <= s3_q[g];
                end
            end
        end
    end

    logic kick_fall;
    logic [1:0] ok;
    logic wd_dis;
    assign kick_fall = (s2_q[PIN_KICK] == s3_q[PIN_KICK]) && !s3_q[PIN_KICK] && pin_q[PIN_KICK];
    assign ok = pin_q[PIN_OK2:PIN_OK1];
    assign wd_dis = pin_q[PIN_WDE];

    // ----------------------------------------------------------------
    // sequencing strap capture
    // ----------------------------------------------------------------
    logic [3:0] strap_cnt_q;
    logic strap_done;
    drww_mode_type mode_q;
    assign strap_done = (strap_cnt_q == STRAP_CYCLES);

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            strap_cnt_q <= 4'h0;
            mode_q <= MODE_OPEN;
        end else if (ce && !strap_done) begin
            strap_cnt_q <= strap_cnt_q + 4'h1;
            case (pin_q[PIN_SEL1:PIN_SEL0])
                SEL_PIN_LOW: mode_q <= MODE_LOW;
                SEL_PIN_HIGH: mode_q <= MODE_HIGH;
                default: mode_q <= MODE_OPEN;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [31:0] por_dly_q [2];
    logic [WIN_W-1:0] win_q;
    logic [IRQ_W-1:0] irq_stat_q;
    logic [IRQ_W-1:0] irq_mask_q;
    logic [IRQ_W-1:0] irq_ev;
    logic wb_hit;
    logic wb_wr;
    logic [31:0] wr_win;
    logic [31:0] wr_mask;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[8*b +: 8] = nw[8*b +: 8];
            end
        end
        return r;
    endfunction

    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr = wb_hit && wb_we_i;
    assign wr_win = merge({{(32-WIN_W){1'b0}}, win_q}, wb_dat_i, wb_sel_i);
    assign wr_mask = merge({{(32-IRQ_W){1'b0}}, irq_mask_q}, wb_dat_i, wb_sel_i);

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            por_dly_q[0] <= POR_DELAY_RST;
            por_dly_q[1] <= POR_DELAY_RST;
            win_q <= WINDOW_RST[WIN_W-1:0];
            irq_mask_q <= IRQ_MASK_RST[IRQ_W-1:0];
        end else if (ce && wb_wr) begin
            case (wb_adr_i)
                OFF_POR1_DELAY: por_dly_q[0] <= merge(por_dly_q[0], wb_dat_i, wb_sel_i);
                OFF_POR2_DELAY: por_dly_q[1] <= merge(por_dly_q[1], wb_dat_i, wb_sel_i);
                OFF_WINDOW: win_q <= (wr_win[WIN_W-1:0] == '0) ? {{(WIN_W-1){1'b0}}, 1'b1} : wr_win[WIN_W-1:0];
                OFF_IRQ_MASK: irq_mask_q <= wr_mask[IRQ_W-1:0];
                default: ;
            endcase
        end
    end

    // sticky status, set wins over write-one-to-clear
    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            irq_stat_q <= '0;
        end else if (ce) begin
            if (wb_wr && wb_adr_i == OFF_IRQ_STAT && wb_sel_i[0]) begin
                irq_stat_q <= (irq_stat_q & ~wb_dat_i[IRQ_W-1:0]) | irq_ev;
            end else begin
                irq_stat_q <= irq_stat_q | irq_ev;
            end
        end
    end
    assign irq = |(irq_stat_q & irq_mask_q);

    // ----------------------------------------------------------------
    // reset channels
    // ----------------------------------------------------------------
    logic [DLY_W-1:0] por_cnt_q [2];
    logic [1:0] por_done_q;
    logic [1:0] ch_en;
    logic [1:0] rst_q;
    logic [1:0] rst_d;
    logic run2_q;
    assign ch_en[0] = strap_done;
    assign ch_en[1] = strap_done && (mode_q == MODE_OPEN || ok[0]);

    for (genvar c = 0; c < 2; c++) begin : g_por
        always_ff @(posedge clk_sys) begin
            if (!rst_b) begin
                por_cnt_q[c] <= '0;
                por_done_q[c] <= 1'b0;
            end else if (ce) begin
                if (!ok[c] || !ch_en[c]) begin
                    por_cnt_q[c] <= '0;
                    por_done_q[c] <= 1'b0;
                end else if (!por_done_q[c]) begin
                    if (por_cnt_q[c] >= por_dly_q[c][DLY_W-1:0]) begin
                        por_done_q[c] <= 1'b1;
                    end else begin
                        por_cnt_q[c] <= por_cnt_q[c] + 1'b1;
                    end
                end
            end
        end
    end

    always_comb begin
        if (mode_q == MODE_LOW) begin
            rst_d = {2{por_done_q[0] && (&ok)}};
        end else begin
            rst_d = por_done_q & ok;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            rst_q <= 2'h0;
            run2_q <= 1'b0;
        end else if (ce) begin
            rst_q <= rst_d;
            run2_q <= ch_en[1];
        end
    end
    assign channel_one_reset_n = rst_q[0];
    assign channel_two_reset_n = rst_q[1];
    assign channel_two_run = run2_q;

    // ----------------------------------------------------------------
    // window watchdog
    // ----------------------------------------------------------------
    drww_wd_state_type wd_state_q;
    logic [CNT_W-1:0] wd_cnt_q;
    logic [CNT_W-1:0] pulse_cnt_q;
    logic [CNT_W-1:0] upper_len;
    logic [CNT_W-1:0] lower_len;
    logic [CNT_W-1:0] pulse_len;
    logic wd_go;
    logic wd_en;
    logic ev_early;
    logic ev_late;
    assign upper_len = {win_q, {UPPER_SHIFT{1'b0}}};
    assign lower_len = {{UPPER_SHIFT{1'b0}}, win_q};
    assign pulse_len = upper_len >> PULSE_SHIFT;
    assign wd_go = (mode_q == MODE_OPEN) ? rst_q[0] : (&rst_q);
    assign wd_en = wd_go && !wd_dis;
    assign ev_early = (wd_state_q == WD_RUN) && wd_en && kick_fall && (wd_cnt_q < lower_len);
    assign ev_late = (wd_state_q == WD_RUN) && wd_en && !ev_early && (wd_cnt_q >= upper_len);
    assign irq_ev = {rst_q[1] && !rst_d[1], rst_q[0] && !rst_d[0], ev_late, ev_early};

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wd_state_q <= WD_IDLE;
        end else if (ce) begin
            case (wd_state_q)
                WD_IDLE: begin
                    if (wd_en) begin
                        wd_state_q <= WD_RUN;
                    end
                end
                WD_RUN: begin
                    if (!wd_en) begin
                        wd_state_q <= WD_IDLE;
                    end else if (ev_early || ev_late) begin
                        wd_state_q <= WD_FAULT;
                    end
                end
                WD_FAULT: begin
                    if (!wd_en) begin
                        wd_state_q <= WD_IDLE;
                    end else if (pulse_cnt_q >= pulse_len - 1'b1) begin
                        wd_state_q <= WD_RUN;
                    end
                end
                default: wd_state_q <= WD_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wd_cnt_q <= '0;
            pulse_cnt_q <= '0;
        end else if (ce) begin
            if (wd_state_q != WD_RUN || !wd_en || kick_fall) begin
                wd_cnt_q <= '0;
            end else if (wd_cnt_q != '1) begin
                wd_cnt_q <= wd_cnt_q + 1'b1;
            end
            pulse_cnt_q <= (wd_state_q == WD_FAULT) ? pulse_cnt_q + 1'b1 : '0;
        end
    end
    assign watchdog_fault_n = (wd_state_q != WD_FAULT);

    // ----------------------------------------------------------------
    // bus read path
    // ----------------------------------------------------------------
    drww_status_type status;
    assign status = '{mode: mode_q, wd_state: wd_state_q, fault_n: watchdog_fault_n, rst_n: rst_q};

    always_ff @(posedge clk_sys) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce) begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= 32'h0000_0000;
            if (wb_hit && !wb_we_i) begin
                case (wb_adr_i)
                    OFF_POR1_DELAY: wb_dat_o <= por_dly_q[0];
                    OFF_POR2_DELAY: wb_dat_o <= por_dly_q[1];
                    OFF_WINDOW: wb_dat_o <= {{(32-WIN_W){1'b0}}, win_q};
                    OFF_STATUS: wb_dat_o <= {24'h00_0000, status};
                    OFF_IRQ_STAT: wb_dat_o <= {{(32-IRQ_W){1'b0}}, irq_stat_q};
                    OFF_IRQ_MASK: wb_dat_o <= {{(32-IRQ_W){1'b0}}, irq_mask_q};
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence s_fault_ends;
        ce && wd_state_q == WD_FAULT && wd_en && pulse_cnt_q >= pulse_len - 1'b1;
    endsequence
    sequence s_good_kick;
        ce && wd_state_q == WD_RUN && wd_en && kick_fall && wd_cnt_q >= lower_len && wd_cnt_q < upper_len;
    endsequence

    AST_RST_UNDER: assert property (ce && !ok[0] |=> !channel_one_reset_n [*2])
        else $error("reset one high while output under threshold");
    AST_RST_DELAY: assert property (ce && mode_q != MODE_LOW && !rst_q[0] && rst_d[0]
        |-> por_cnt_q[0] >= por_dly_q[0][DLY_W-1:0])
        else $error("reset one released before its delay");
    AST_CHANNEL_TWO_RESET_N_DELAY: assert property (ce && mode_q != MODE_LOW && !rst_q[1] && rst_d[1]
        |-> por_cnt_q[1] >= por_dly_q[1][DLY_W-1:0])
        else $error("reset two released before its own delay");
    AST_WD_DISABLE: assert property (ce && wd_dis |=> wd_state_q == WD_IDLE && watchdog_fault_n)
        else $error("watchdog active while disabled");
    AST_EARLY_FAULT: assert property (ce && ev_early |=> !watchdog_fault_n ##0 irq_stat_q[IRQ_EARLY])
        else $error("early kick did not raise fault");
    AST_LATE_FAULT: assert property (ce && wd_state_q == WD_RUN && wd_en && !kick_fall
        && wd_cnt_q >= {win_q, 4'h0} |=> !watchdog_fault_n)
        else $error("missed kick did not raise fault");
    AST_PULSE_LEN: assert property (!watchdog_fault_n |-> pulse_cnt_q < (upper_len >> 3))
        else $error("fault pulse longer than an eighth of upper bound");
    AST_PULSE_END: assert property (s_fault_ends |=> watchdog_fault_n ##0 wd_cnt_q == '0)
        else $error("fault pulse did not end on timeout");
    AST_FAULT_ABORT: assert property (ce && !wd_go |=> watchdog_fault_n)
        else $error("fault held while a reset is low");
    AST_CHAIN: assert property (ce && mode_q == MODE_HIGH && !ok[0]
        |=> !channel_two_run ##1 !channel_two_reset_n)
        else $error("channel two started before channel one");
    AST_JOINT: assert property (ce && mode_q == MODE_LOW && !(&ok)
        |=> !channel_one_reset_n && !channel_two_reset_n)
        else $error("joint resets released early");
    AST_OPEN_START: assert property (ce && mode_q == MODE_OPEN && rst_q[0] && !wd_dis
        && wd_state_q == WD_IDLE |=> wd_state_q == WD_RUN)
        else $error("watchdog did not start on first reset");
    AST_IDLE_CLEAR: assert property (wd_state_q == WD_IDLE |-> watchdog_fault_n && wd_cnt_q == '0)
        else $error("idle watchdog not cleared");
    AST_KICK_RESTART: assert property (s_good_kick |=> wd_state_q == WD_RUN ##0 wd_cnt_q == '0)
        else $error("accepted kick did not restart window");
endmodule

/* tb.sv */
/*
 * Self-checking bench of the supervisor: bus, reset channels, window watchdog, irq.
 * Assumes drww_pkg, drww_supervisor and drww_kick_model; ce is tied high.
 */
`timescale 1ns/1ps
module tb;
    import drww_pkg::*;
    logic clk_sys = 1'h0;
    logic rst_b = 1'h0;
    logic wb_cyc_i = 1'h0;
    logic wb_stb_i = 1'h0;
    logic wb_we_i = 1'h0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o, q;
    logic wb_ack_o, watchdog_kick_in, channel_one_reset_n, channel_two_reset_n;
    logic watchdog_fault_n, channel_two_run, irq;
    logic [1:0] output_feedback_sense = 2'h0;
    logic watchdog_disable_in = 1'h0;
    logic [1:0] seq_select_in = 2'h2;
    logic [1:0] straps[3] = '{SEL_PIN_HIGH, SEL_PIN_LOW, 2'h0};
    drww_mode_type modes[3] = '{MODE_HIGH, MODE_LOW, MODE_OPEN};
    int err_total = 0;
    int samples_checked = 0;
    int fault_lows = 0;
    int regs[int];
    int n, t1, t2, d1, d2, up;

    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (watchdog_fault_n === 1'h0) fault_lows++;

    drww_supervisor i_drww_supervisor (.clk_sys(clk_sys), .rst_b(rst_b), .ce(1'h1), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .output_feedback_sense(output_feedback_sense),
        .watchdog_kick_in(watchdog_kick_in), .watchdog_disable_in(watchdog_disable_in),
        .seq_select_in(seq_select_in), .channel_one_reset_n(channel_one_reset_n),
        .channel_two_reset_n(channel_two_reset_n), .watchdog_fault_n(watchdog_fault_n),
        .channel_two_run(channel_two_run), .irq(irq));
    drww_kick_model i_drww_kick_model (.clk_sys(clk_sys), .watchdog_kick_in(watchdog_kick_in));

    // ----------------------------------------------------------------
    // checking and bus tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic xfer(input logic [7:0] a, input logic we, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge clk_sys);
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        do begin
            @(posedge clk_sys);
            k++;
        end while (wb_ack_o !== 1'h1 && k < 40);
        q = wb_dat_o;
        if (k >= 40) chk("bus ack", 32'h0000_0001, 32'h0000_0000);
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        wb_we_i <= 1'h0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'h1, d);
        if (a == OFF_IRQ_STAT) regs[a] = regs[a] & ~(d & 32'h0000_00FF);
        else if (a == OFF_WINDOW) regs[a] = (d[15:0] == 16'h0000) ? 1 : d[15:0];
        else if (regs.exists(a)) regs[a] = d;
    endtask
    task automatic rd(input logic [7:0] a, input string what);
        xfer(a, 1'h0, 32'h0000_0000);
        chk(what, regs.exists(a) ? regs[a] : 0, q);
    endtask
    task automatic st_chk(input drww_mode_type m, input drww_wd_state_type w, input logic [1:0] r);
        drww_status_type s;
        s = '{mode: m, wd_state: w, fault_n: 1'h1, rst_n: r};
        xfer(OFF_STATUS, 1'h0, 32'h0000_0000);
        chk("status", {24'h00_0000, s}, q);
    endtask
    task automatic irq_chk;
        chk("irq", 32'((regs[OFF_IRQ_STAT] & regs[OFF_IRQ_MASK]) != 0), irq);
    endtask
    function automatic logic pick(input int k);
        return (k == 0) ? watchdog_fault_n : (k == 1) ? channel_one_reset_n : channel_two_reset_n;
    endfunction
    task automatic wait_sig(input int k, input logic v, input int lim);
        n = 0;
        while (pick(k) !== v && n < lim) begin
            @(posedge clk_sys);
            n++;
        end
        if (pick(k) !== v) chk("wait limit", 32'h0000_0001, 32'h0000_0000);
    endtask
    task automatic do_reset(input logic [1:0] strap);
        rst_b <= 1'h0;
        seq_select_in <= strap;
        output_feedback_sense <= 2'h0;
        watchdog_disable_in <= 1'h0;
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'h1;
        repeat (14) @(posedge clk_sys);
        regs.delete();
        regs[OFF_POR1_DELAY] = POR_DELAY_RST;
        regs[OFF_POR2_DELAY] = POR_DELAY_RST;
        regs[OFF_WINDOW] = WINDOW_RST;
        regs[OFF_IRQ_STAT] = 0;
        regs[OFF_IRQ_MASK] = IRQ_MASK_RST;
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        repeat (30000) @(posedge clk_sys);
        err_total++;
        $display("[FAIL] run length expected finish seen hang");
        complete_run;
    end
    initial begin
        void'($urandom(32'h991373F5));
        do_reset(SEL_PIN_HIGH);
        foreach (regs[a]) rd(8'(a), "reset value");
        wr(8'h18, 32'hFFFF_FFFF);
        rd(8'h18, "unmapped");
        wr(OFF_STATUS, 32'hFFFF_FFFF);
        st_chk(MODE_HIGH, WD_IDLE, 2'h0);
        wr(OFF_WINDOW, 32'h0000_0000);
        rd(OFF_WINDOW, "window zero");
        wr(OFF_POR1_DELAY, $urandom & 32'h00FF_FFFF);
        wr(OFF_POR2_DELAY, $urandom & 32'h00FF_FFFF);
        wr(OFF_IRQ_MASK, $urandom & 32'h0000_000F);
        foreach (regs[a]) rd(8'(a), "readback");
        $display("register test done");
        for (int i = 0; i < 3; i++) begin
            do_reset(straps[i]);
            wr(OFF_POR1_DELAY, 32'h0000_0010);
            wr(OFF_POR2_DELAY, 32'h0000_0030);
            output_feedback_sense <= 2'h1;
            repeat (60) @(posedge clk_sys);
            chk("reset one", 32'(i != 1), channel_one_reset_n);
            chk("reset two", 32'h0000_0000, channel_two_reset_n);
            chk("channel two run", 32'h0000_0001, channel_two_run);
            st_chk(modes[i], (i == 2) ? WD_RUN : WD_IDLE, {1'h0, i != 1});
            output_feedback_sense <= 2'h3;
            repeat (100) @(posedge clk_sys);
            st_chk(modes[i], WD_RUN, 2'h3);
        end
        $display("sequencing test done");
        do_reset(2'h0);
        d1 = $urandom_range(40, 16);
        d2 = d1 + $urandom_range(30, 1);
        wr(OFF_POR1_DELAY, 32'(d1));
        wr(OFF_POR2_DELAY, 32'(d2));
        output_feedback_sense <= 2'h3;
        wait_sig(1, 1'h1, 200);
        t1 = n;
        wait_sig(2, 1'h1, 200);
        t2 = t1 + n;
        chk("reset one delay", 32'h0000_0001, 32'(t1 >= d1 && t1 <= d1 + 8));
        chk("reset delay gap", 32'(d2 - d1), 32'(t2 - t1));
        output_feedback_sense <= 2'h2;
        wait_sig(1, 1'h0, 20);
        chk("reset one falls", 32'h0000_0001, 32'(n <= 7));
        chk("reset two holds", 32'h0000_0001, channel_two_reset_n);
        $display("reset channel test done");
        do_reset(SEL_PIN_HIGH);
        wr(OFF_POR1_DELAY, 32'h0000_0010);
        wr(OFF_POR2_DELAY, 32'h0000_0010);
        wr(OFF_WINDOW, 32'h0000_0008);
        wr(OFF_IRQ_MASK, 32'h0000_0001);
        up = regs[OFF_WINDOW] << UPPER_SHIFT;
        output_feedback_sense <= 2'h3;
        wait_sig(2, 1'h1, 100);
        t1 = fault_lows;
        repeat (20) i_drww_kick_model.kick($urandom_range(120, 12));
        chk("no fault in window", 32'(t1), 32'(fault_lows));
        i_drww_kick_model.kick(6);
        wait_sig(0, 1'h0, 20);
        wait_sig(0, 1'h1, 40);
        chk("fault pulse", 32'(up >> PULSE_SHIFT), 32'(n));
        regs[OFF_IRQ_STAT] = 1;
        irq_chk();
        wait_sig(0, 1'h0, 300);
        chk("late after pulse", 32'h0000_0001, 32'(n >= up - 1 && n <= up + 5));
        wait_sig(0, 1'h1, 40);
        chk("fault pulse", 32'(up >> PULSE_SHIFT), 32'(n));
        regs[OFF_IRQ_STAT] = 3;
        rd(OFF_IRQ_STAT, "irq status");
        wr(OFF_IRQ_MASK, 32'h0000_0002);
        irq_chk();
        wr(OFF_IRQ_STAT, 32'h0000_0002);
        irq_chk();
        wr(OFF_IRQ_MASK, 32'h0000_0001);
        irq_chk();
        wr(OFF_IRQ_STAT, 32'h0000_0001);
        irq_chk();
        rd(OFF_IRQ_STAT, "irq cleared");
        $display("window test done");
        watchdog_disable_in <= 1'h1;
        repeat (8) @(posedge clk_sys);
        t1 = fault_lows;
        repeat (400) @(posedge clk_sys);
        chk("disabled no fault", 32'(t1), 32'(fault_lows));
        st_chk(MODE_HIGH, WD_IDLE, 2'h3);
        watchdog_disable_in <= 1'h0;
        wait_sig(0, 1'h0, 300);
        chk("fresh window", 32'h0000_0001, 32'(n >= up && n <= up + 10));
        output_feedback_sense <= 2'h2;
        wait_sig(0, 1'h1, 30);
        chk("fault cut by reset", 32'h0000_0001, 32'(n <= 10));
        chk("reset one low", 32'h0000_0000, channel_one_reset_n);
        $display("disable and cut test done");
        complete_run;
    end
endmodule
